// >>> hw/swh_pkg.sv
/*
   swh_pkg: constants, register map and carrier types of the sweep holdoff
   sequencer. Assumes a 250 MHz system clock and an Avalon-MM register bus
   with byte addresses on aligned 32-bit words.
*/
package swh_pkg;

   // clock
   localparam int unsigned CLK_MHZ        = 250;

   // register byte offsets
   localparam logic [3:0]  OFS_CTRL       = 4'h0;
   localparam logic [3:0]  OFS_HOLDOFF    = 4'h4;
   localparam logic [3:0]  OFS_DELAY      = 4'h8;
   localparam logic [3:0]  OFS_STATUS     = 4'hc;

   // control register fields
   localparam int unsigned CTRL_SINGLE    = 0;
   localparam int unsigned CTRL_AUTO_N    = 1;
   localparam int unsigned CTRL_LOCKOUT   = 2;
   localparam int unsigned CTRL_RAD       = 3;
   localparam int unsigned CTRL_B_EN      = 4;
   localparam int unsigned CTRL_ARM       = 8;
   localparam logic [4:0]  CTRL_RST       = 5'h02;

   // holdoff register fields
   localparam int unsigned HO_RANGE_LSB   = 0;
   localparam int unsigned HO_VAR_LSB     = 8;
   localparam logic [2:0]  HO_RANGE_RST   = 3'h0;
   localparam logic [7:0]  HO_VAR_RST     = 8'h00;

   // delay position reset value
   localparam logic [15:0] DELAY_RST      = 16'h0000;

   // timing, figures in their own units, counts derived from the clock
   localparam int unsigned AUTO_TMO_MS    = 100;
   localparam int unsigned AUTO_CYC       = AUTO_TMO_MS * CLK_MHZ * 1000;
   localparam int unsigned REEN_US        = 1000;
   localparam int unsigned REEN_CYC       = REEN_US * CLK_MHZ;
   localparam int unsigned RST_PULSE_NS   = 1000;
   localparam int unsigned RST_PULSE_CYC  = RST_PULSE_NS * CLK_MHZ / 1000;
   localparam int unsigned HO_BASE_NS     = 2000;
   localparam int unsigned HO_BASE_CYC    = HO_BASE_NS * CLK_MHZ / 1000;

   // sequencer states, gray along holdoff -> armed -> sweep
   typedef enum logic [1:0]
   {
      ST_HOLD  = 2'h0,
      ST_ARMED = 2'h1,
      ST_SWEEP = 2'h3,
      ST_SPENT = 2'h2
   } swh_state_t;

   typedef struct packed
   {
      logic b_en;
      logic rad;
      logic lockout;
      logic auto_n;
      logic single;
   } swh_ctrl_t;

   typedef struct packed
   {
      logic       pickoff;
      logic       auto_gate;
      logic       ready;
      logic       lamp;
      logic       sweep_disable;
      logic       holdoff_n;
      logic       b_gate;
      logic       a_gate;
   } swh_status_t;

endpackage

// >>> hw/swh_sequencer.sv
/*
   swh_sequencer: sweep gates, holdoff timer, auto/normal/single trigger
   modes, storage holdoff handling and delay pickoff, with an Avalon-MM
   register slave. Assumes trigger and sweep-end pulses synchronous to
   CLK_SYS and one cycle or longer; the A ramp is a cycle count from the
   start of each A sweep.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - trigger pulse sets sweep gate, starts sweep
// - auto: no trigger in 100 ms fires gate
// - lamp shows a triggered sweep gate occurred
// - storage holdoff holds holdoff timer at zero
// - holdoff status low only during holdoff
// - single select high gives single-shot sweeps
// - ready indicator while armed in single mode
// - arm request arms and lights ready
// - sweep end pulse starts holdoff
// - sweep disable high throughout holdoff
// - lockout suppresses all sweep activity
// - auto control low selects auto mode
// - threshold ends holdoff, clears timer, releases disable unless single mode is unarmed
// - holdoff length per range plus variable extension
// - storage holdoff rise makes short reset pulse
// - holdoff timing waits for storage holdoff fall
// - storage holdoff forces normal mode internally
// - auto restored only after extra interval
// - normal or single never auto triggers
// - B reset released when disable low, pickoff high
// - pickoff when A ramp reaches delay level
// - after pickoff B starts now or on trigger
// - run-after-delay makes B trigger free-running
module swh_sequencer
   import swh_pkg::*;
#(
   parameter int unsigned AUTO_CYC_P = AUTO_CYC,
   parameter int unsigned REEN_CYC_P = REEN_CYC
)
(
   // clock, reset, enable
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   input  wire logic        CE,
   // avalon-mm slave
   input  wire logic [3:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   // trigger generators
   input  wire logic        A_ARMED_EVENT_LAMP,
   input  wire logic        B_ARMED_EVENT_LAMP,
   output logic             SWEEP_DISABLE,
   output logic             B_ARMED_EVENT_LAMP_RESET,
   output logic             B_FREE_RUN,
   // sweep generators
   input  wire logic        SWEEP_END,
   output logic             A_GATE,
   output logic             B_GATE,
   // storage time base and front panel
   input  wire logic        STORAGE_HOLDOFF_IN,
   input  wire logic        ONE_SHOT_ARM,
   output logic             HOLDOFF_N,
   output logic             ARMED_EVENT_LAMP,
   output logic             READY_LAMP,
   output logic             AUTO_GATE
);

   swh_state_t  state_ff, nxt_state;
   swh_ctrl_t   ctrl_ff;
   logic [2:0]  range_ff;
   logic [7:0]  var_ff;
   logic [15:0] delay_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] ho_cnt_ff;
   logic [31:0] auto_cnt_ff;
   logic [31:0] reen_cnt_ff;
   logic [31:0] rp_cnt_ff;
   logic [15:0] ramp_ff;
   logic        sh_d_ff;
   logic        armed_ff;
   logic        lamp_ff;
   logic        auto_gate_ff;
   logic        pickoff_ff;
   logic        b_gate_ff;

   // bus decode
   wire         req        = READ | WRITE;
   wire         wr_take    = WRITE & ack_ff & CE;
   wire         sel_ctrl   = ADDRESS == OFS_CTRL;
   wire         sel_ho     = ADDRESS == OFS_HOLDOFF;
   wire         sel_dly    = ADDRESS == OFS_DELAY;
   wire         sel_stat   = ADDRESS == OFS_STATUS;
   wire         arm_wr     = wr_take & sel_ctrl & WRITEDATA[CTRL_ARM];
   wire         arm_req    = arm_wr | ONE_SHOT_ARM;

   // mode decode
   wire         single     = ctrl_ff.single;
   wire         sh_rise    = STORAGE_HOLDOFF_IN & ~sh_d_ff;
   wire         rst_pulse  = sh_rise | (rp_cnt_ff != 32'h0);
   // auto needs the panel selection, no single mode and the re-enable gap
   wire         auto_eff   = ~ctrl_ff.auto_n & ~single
                             & ~STORAGE_HOLDOFF_IN
                             & (reen_cnt_ff == 32'h0);

   // holdoff target grows by a factor of two per range step
   wire  [31:0] ho_target  = (32'(HO_BASE_CYC) << range_ff)
                             + (32'(var_ff) << range_ff);
   wire         ho_done    = ho_cnt_ff >= ho_target;
   wire         auto_fire  = auto_eff & (auto_cnt_ff >= AUTO_CYC_P - 1);
   wire         a_start    = A_ARMED_EVENT_LAMP | auto_fire;

   // status view
   wire         holdoff    = state_ff == ST_HOLD;
   wire         sw_dis     = (state_ff != ST_ARMED) & (state_ff != ST_SWEEP);
   wire         a_gate     = state_ff == ST_SWEEP;
   wire         b_reset    = sw_dis | ~pickoff_ff;
   wire         b_go       = ~b_reset & a_gate & (ctrl_ff.rad | B_ARMED_EVENT_LAMP);
   swh_status_t status;
   assign status.pickoff       = pickoff_ff;
   assign status.auto_gate     = auto_gate_ff;
   assign status.ready         = READY_LAMP;
   assign status.lamp          = lamp_ff;
   assign status.sweep_disable = sw_dis;
   assign status.holdoff_n     = ~holdoff;
   assign status.b_gate        = b_gate_ff;
   assign status.a_gate        = a_gate;

   wire  [31:0] rd_mux     = sel_ctrl ? {27'h0, ctrl_ff}
                           : sel_ho   ? {16'h0, var_ff, 5'h0, range_ff}
                           : sel_dly  ? {16'h0, delay_ff}
                           : sel_stat ? {24'h0, status}
                           : 32'h0;

   // sequencer
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_HOLD:
         begin
            if (ho_done & ~STORAGE_HOLDOFF_IN)
            begin
               nxt_state = (single & ~armed_ff) ? ST_SPENT : ST_ARMED;
            end
         end
         ST_ARMED:
         begin
            if (a_start)
            begin
               nxt_state = ST_SWEEP;
            end
         end
         ST_SWEEP:
         begin
            if (SWEEP_END)
            begin
               nxt_state = ST_HOLD;
            end
         end
         ST_SPENT:
         begin
            if (arm_req)
            begin
               nxt_state = ST_ARMED;
            end
         end
      endcase
      if (rst_pulse | ctrl_ff.lockout)
      begin
         nxt_state = ST_HOLD;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_ff <= ST_HOLD;
      end
      else if (CE)
      begin
         state_ff <= nxt_state;
      end
   end

   // bus slave: one wait cycle, read data loaded while waiting
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
      end
      else if (CE)
      begin
         ack_ff   <= req & ~ack_ff;
         rdata_ff <= (READ & ~ack_ff) ? rd_mux : rdata_ff;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ctrl_ff  <= CTRL_RST;
         range_ff <= HO_RANGE_RST;
         var_ff   <= HO_VAR_RST;
         delay_ff <= DELAY_RST;
      end
      else if (wr_take)
      begin
         ctrl_ff  <= sel_ctrl ? WRITEDATA[4:0] : ctrl_ff;
         range_ff <= sel_ho ? WRITEDATA[HO_RANGE_LSB +: 3] : range_ff;
         var_ff   <= sel_ho ? WRITEDATA[HO_VAR_LSB +: 8] : var_ff;
         delay_ff <= sel_dly ? WRITEDATA[15:0] : delay_ff;
      end
   end

   // interval counters on the system clock
   wire  [31:0] nxt_rp_cnt   = sh_rise ? 32'(RST_PULSE_CYC - 1)
                             : (rp_cnt_ff != 32'h0) ? rp_cnt_ff - 32'h1 : 32'h0;
   wire  [31:0] nxt_reen_cnt = STORAGE_HOLDOFF_IN ? 32'(REEN_CYC_P)
                             : (reen_cnt_ff != 32'h0) ? reen_cnt_ff - 32'h1 : 32'h0;
   // timer held at zero while storage holdoff is high
   wire  [31:0] nxt_ho_cnt   = (state_ff != ST_HOLD) | STORAGE_HOLDOFF_IN | ho_done
                             ? 32'h0 : ho_cnt_ff + 32'h1;
   // timeout runs from the end of holdoff while armed
   wire  [31:0] nxt_auto_cnt = (state_ff != ST_ARMED) | ~auto_eff | A_ARMED_EVENT_LAMP
                             ? 32'h0 : auto_cnt_ff + 32'h1;

   // edge detector starts low, the idle level of the storage holdoff pin
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sh_d_ff <= 1'b0;
      end
      else if (CE)
      begin
         sh_d_ff <= STORAGE_HOLDOFF_IN;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rp_cnt_ff <= 32'h0;
      end
      else if (CE)
      begin
         rp_cnt_ff <= nxt_rp_cnt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         reen_cnt_ff <= 32'h0;
      end
      else if (CE)
      begin
         reen_cnt_ff <= nxt_reen_cnt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ho_cnt_ff <= 32'h0;
      end
      else if (CE)
      begin
         ho_cnt_ff <= nxt_ho_cnt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         auto_cnt_ff <= 32'h0;
      end
      else if (CE)
      begin
         auto_cnt_ff <= nxt_auto_cnt;
      end
   end

   // single-shot arming and indicators
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         armed_ff     <= 1'b0;
         lamp_ff      <= 1'b0;
         auto_gate_ff <= 1'b0;
      end
      else if (CE)
      begin
         // the arm request wins over the clear by a starting sweep
         armed_ff     <= arm_req | (armed_ff & ~(nxt_state == ST_SWEEP
                                                & state_ff == ST_ARMED));
         if (state_ff == ST_ARMED && a_start && !rst_pulse && !ctrl_ff.lockout)
         begin
            lamp_ff      <= A_ARMED_EVENT_LAMP;
            auto_gate_ff <= ~A_ARMED_EVENT_LAMP;
         end
         else if (nxt_state != ST_SWEEP)
         begin
            auto_gate_ff <= 1'b0;
         end
      end
   end

   // delay pickoff and B sweep gate
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ramp_ff    <= 16'h0;
         pickoff_ff <= 1'b0;
         b_gate_ff  <= 1'b0;
      end
      else if (CE)
      begin
         ramp_ff    <= a_gate && ramp_ff != 16'hffff ? ramp_ff + 16'h1 : 16'h0;
         pickoff_ff <= ctrl_ff.b_en & a_gate & (ramp_ff >= delay_ff);
         // B sweep ends with its A sweep
         b_gate_ff  <= ctrl_ff.b_en & (nxt_state == ST_SWEEP) & (b_gate_ff | b_go);
      end
   end

   // outputs
   assign WAITREQUEST      = req & ~ack_ff;
   assign READDATA         = rdata_ff;
   assign A_GATE           = a_gate;
   assign B_GATE           = b_gate_ff;
   assign SWEEP_DISABLE    = sw_dis;
   assign HOLDOFF_N        = ~holdoff;
   assign B_ARMED_EVENT_LAMP_RESET     = b_reset;
   assign B_FREE_RUN       = ctrl_ff.rad;
   assign ARMED_EVENT_LAMP = lamp_ff;
   assign READY_LAMP       = single & armed_ff & (state_ff != ST_SWEEP);
   assign AUTO_GATE        = auto_gate_ff;

endmodule // swh_sequencer

// >>> tb/swh_far_model.sv
/*
   swh_far_model: A trigger generator and A sweep generator behaviour.
   assumes the sequencer samples pulses on the rising clock edge.
*/
`timescale 1ns/10ps
module swh_far_model
#(
   parameter int unsigned SWEEP_LEN = 60
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // sequencer side
   input  wire logic a_gate,
   input  wire logic sweep_disable,
   input  wire logic fire,
   output logic      a_armed_event_lamp,
   output logic      sweep_end
);
   logic [7:0] len_ff;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         a_armed_event_lamp    <= 1'b0;
         sweep_end <= 1'b0;
         len_ff    <= 8'h00;
      end
      else
      begin
         // generator stays quiet while held in reset by the disable level
         a_armed_event_lamp    <= fire & ~sweep_disable & ~a_armed_event_lamp;
         len_ff    <= a_gate ? len_ff + 8'h01 : 8'h00;
         sweep_end <= a_gate && (len_ff == SWEEP_LEN[7:0]);
      end
   end
endmodule // swh_far_model

// >>> tb/swh_sequencer_monitor.sv
/*
   swh_sequencer_monitor: port checks of the sweep sequencer.
   assumes trigger pulses from the far-side model; the holdoff count freezes with CE.
*/
`timescale 1ns/10ps
module swh_sequencer_monitor
(
   // clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic CE,
   // sweep link
   input wire logic A_ARMED_EVENT_LAMP,
   input wire logic SWEEP_END,
   input wire logic A_GATE,
   input wire logic B_GATE,
   input wire logic SWEEP_DISABLE,
   input wire logic B_ARMED_EVENT_LAMP_RESET,
   // storage and panel
   input wire logic STORAGE_HOLDOFF_IN,
   input wire logic HOLDOFF_N,
   input wire logic ARMED_EVENT_LAMP,
   input wire logic READY_LAMP,
   input wire logic AUTO_GATE
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_B);

   // low time of the running holdoff; frozen with CE like the design
   logic [15:0] ho_cnt_ff;
   wire  logic [15:0] nxt_ho_cnt = HOLDOFF_N ? 16'h0000 : ho_cnt_ff + {15'h0000, CE};

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         ho_cnt_ff <= 16'h0000;
      else
         ho_cnt_ff <= nxt_ho_cnt;
   end

   a_hold_disable: assert property (!HOLDOFF_N |-> SWEEP_DISABLE)
      else $error("sweep disable low during holdoff");
   a_end_holdoff: assert property (CE && A_GATE && SWEEP_END |=>
      !HOLDOFF_N && !A_GATE && !B_GATE) else $error("sweep end did not start holdoff");
   a_armed_event_lamp_start: assert property (CE && A_ARMED_EVENT_LAMP && !SWEEP_DISABLE && !A_GATE
      && !STORAGE_HOLDOFF_IN |=> A_GATE && ARMED_EVENT_LAMP && !AUTO_GATE)
      else $error("trigger did not start a triggered sweep");
   a_ready_idle: assert property (READY_LAMP |-> !A_GATE && !SWEEP_DISABLE)
      else $error("ready lit while not armed");
   a_auto_blocked: assert property (STORAGE_HOLDOFF_IN |=> !$rose(AUTO_GATE))
      else $error("auto gate during storage holdoff");
   a_storage_hold: assert property (STORAGE_HOLDOFF_IN && $past(STORAGE_HOLDOFF_IN, 3)
      |-> !HOLDOFF_N) else $error("holdoff ended under storage holdoff");
   a_breset_gate: assert property (SWEEP_DISABLE |-> B_ARMED_EVENT_LAMP_RESET)
      else $error("b trigger released in holdoff");
   a_b_start: assert property ($rose(B_GATE) |-> !$past(B_ARMED_EVENT_LAMP_RESET))
      else $error("b sweep started while b trigger held");
   a_holdoff_length: assert property ($rose(HOLDOFF_N) |-> ho_cnt_ff >= 16'h01f4)
      else $error("holdoff shorter than base interval");
endmodule // swh_sequencer_monitor

bind swh_sequencer swh_sequencer_monitor u_mon
(
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .A_ARMED_EVENT_LAMP(A_ARMED_EVENT_LAMP), .SWEEP_END(SWEEP_END),
   .A_GATE(A_GATE), .B_GATE(B_GATE), .SWEEP_DISABLE(SWEEP_DISABLE),
   .B_ARMED_EVENT_LAMP_RESET(B_ARMED_EVENT_LAMP_RESET), .STORAGE_HOLDOFF_IN(STORAGE_HOLDOFF_IN),
   .HOLDOFF_N(HOLDOFF_N), .ARMED_EVENT_LAMP(ARMED_EVENT_LAMP),
   .READY_LAMP(READY_LAMP), .AUTO_GATE(AUTO_GATE)
);

// >>> tb/tb_swh_sequencer.sv
/*
   tb_swh_sequencer: directed scenarios of the sweep sequencer.
   assumes shortened auto and re-enable counts; CE low only in one freeze span.
*/
`timescale 1ns/10ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("FAIL %s exp %0h got %0h", nm, e, a); end end
`define WAITC(c, m) begin n = 0; while (!(c) && n < (m)) begin @(posedge clk); n++; end end
module tb_swh_sequencer
   import swh_pkg::*;
;
   logic        clk, rst_b, rd, wr, b_armed_event_lamp, sto_ho, arm, fire, bad, ce;
   logic [3:0]  addr;
   logic [31:0] wdata, rv;
   wire  logic [31:0] rdata;
   wire  logic  wait_req, a_armed_event_lamp, sw_end, sw_dis, b_rst, b_free;
   wire  logic  a_gate, b_gate, ho_n, lamp, ready, auto_g;
   int          error_cnt, cmp_count, n;

   swh_sequencer #(.AUTO_CYC_P(50), .REEN_CYC_P(2000)) dut
   (
      .CLK_SYS(clk), .RST_B(rst_b), .CE(ce), .ADDRESS(addr), .READ(rd), .WRITE(wr),
      .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(wait_req), .A_ARMED_EVENT_LAMP(a_armed_event_lamp),
      .B_ARMED_EVENT_LAMP(b_armed_event_lamp), .SWEEP_DISABLE(sw_dis), .B_ARMED_EVENT_LAMP_RESET(b_rst), .B_FREE_RUN(b_free),
      .SWEEP_END(sw_end), .A_GATE(a_gate), .B_GATE(b_gate), .STORAGE_HOLDOFF_IN(sto_ho),
      .ONE_SHOT_ARM(arm), .HOLDOFF_N(ho_n), .ARMED_EVENT_LAMP(lamp), .READY_LAMP(ready),
      .AUTO_GATE(auto_g)
   );

   swh_far_model u_far
   (
      .clk(clk), .rst_b(rst_b), .a_gate(a_gate), .sweep_disable(sw_dis), .fire(fire),
      .a_armed_event_lamp(a_armed_event_lamp), .sweep_end(sw_end)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // held until the sampling edge shows waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      do @(posedge clk); while (wait_req !== 1'b0);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task t_regs;
      bus(1'b0, OFS_CTRL, 32'h0);
      `CHK("ctrl", {27'h0, CTRL_RST}, rv)
      bus(1'b0, OFS_DELAY, 32'h0);
      `CHK("delay", {16'h0, DELAY_RST}, rv)
      bus(1'b1, OFS_STATUS, 32'hff);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", 32'h8, rv)
      bus(1'b1, OFS_HOLDOFF, 32'h101);
      bus(1'b0, OFS_HOLDOFF, 32'h0);
      `CHK("holdoff", 32'h101, rv)
      bus(1'b1, OFS_CTRL, 32'h102);
      bus(1'b0, OFS_CTRL, 32'h0);
      `CHK("arm", 32'h2, rv)
      $display("t_regs done");
   endtask

   task t_normal;
      `WAITC(ho_n === 1'b1, 2000)
      `CHK("dis", 1'b0, sw_dis)
      repeat (100) @(posedge clk);
      `CHK("noauto", 1'b0, a_gate)
      fire <= 1'b1;
      `WAITC(a_gate === 1'b1, 8)
      fire <= 1'b0;
      `CHK("armed_event_lamp", 3'b110, {a_gate, lamp, auto_g})
      `WAITC(ho_n === 1'b0, 100)
      // a frozen enable must stretch holdoff by exactly the frozen span
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      `WAITC(ho_n === 1'b1, 2000)
      `CHK("holdlen", 1003, n)
      $display("t_normal done");
   endtask

   task t_auto;
      bus(1'b1, OFS_CTRL, 32'h0);
      `WAITC(auto_g === 1'b1, 200)
      `CHK("auto", 3'b101, {a_gate, lamp, auto_g})
      `WAITC(ho_n === 1'b0, 100)
      `WAITC(ho_n === 1'b1, 2000)
      `WAITC(auto_g === 1'b1, 200)
      `CHK("autotime", 1'b1, n >= 45 && n <= 55)
      $display("t_auto done");
   endtask

   task t_storage;
      sto_ho <= 1'b1;
      `WAITC(a_gate === 1'b0, 4)
      `CHK("storst", 1'b0, a_gate)
      bad = 1'b0;
      repeat (4) @(posedge clk);
      repeat (400)
      begin
         @(posedge clk);
         if (ho_n !== 1'b0 || auto_g !== 1'b0) bad = 1'b1;
      end
      `CHK("stohold", 1'b0, bad)
      sto_ho <= 1'b0;
      `WAITC(auto_g === 1'b1, 4000)
      `CHK("reen", 1'b1, n >= 2000 && auto_g === 1'b1)
      $display("t_storage done");
   endtask

   task t_single;
      bus(1'b1, OFS_CTRL, 32'h3);
      `WAITC(a_gate === 1'b0, 200)
      `WAITC(ho_n === 1'b0, 10)
      `WAITC(ho_n === 1'b1, 2000)
      repeat (20) @(posedge clk);
      `CHK("spent", 3'b010, {a_gate, sw_dis, ready})
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      `WAITC(ready === 1'b1, 4)
      `CHK("ready", 2'b10, {ready, sw_dis})
      fire <= 1'b1;
      `WAITC(a_gate === 1'b1, 8)
      fire <= 1'b0;
      `CHK("one", 2'b10, {a_gate, ready})
      `WAITC(ho_n === 1'b0, 100)
      `WAITC(ho_n === 1'b1, 2000)
      repeat (4) @(posedge clk);
      `CHK("again", 1'b1, sw_dis)
      $display("t_single done");
   endtask

   task t_lock_b;
      bus(1'b1, OFS_CTRL, 32'h6);
      fire <= 1'b1;
      repeat (1500) @(posedge clk);
      `CHK("lock", 2'b01, {a_gate, sw_dis})
      bus(1'b1, OFS_DELAY, 32'ha);
      bus(1'b1, OFS_CTRL, 32'h1a);
      @(posedge clk);
      `CHK("free", 1'b1, b_free)
      `WAITC(a_gate === 1'b1, 2000)
      `WAITC(b_gate === 1'b1, 40)
      `CHK("pick", 1'b1, n >= 10 && b_gate === 1'b1)
      fire <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h12);
      `WAITC(a_gate === 1'b0, 100)
      fire <= 1'b1;
      `WAITC(a_gate === 1'b1, 2000)
      fire <= 1'b0;
      repeat (30) @(posedge clk);
      `CHK("bwait", 2'b00, {b_gate, b_rst})
      b_armed_event_lamp <= 1'b1;
      @(posedge clk);
      b_armed_event_lamp <= 1'b0;
      `WAITC(b_gate === 1'b1, 4)
      `CHK("btrig", 1'b1, b_gate)
      $display("t_lock_b done");
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // generous span: the scenarios need about 12000 cycles
   initial
   begin
      #120000;
      error_cnt++;
      $display("watchdog expired");
      final_report;
   end

   initial
   begin
      {rst_b, rd, wr, b_armed_event_lamp, sto_ho, arm, fire} = 7'h00;
      ce    = 1'b1;
      addr  = 4'h0;
      wdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_normal;
      t_auto;
      t_storage;
      t_single;
      t_lock_b;
      final_report;
   end
endmodule // tb_swh_sequencer
